// ==== rtl/npic_ctrl.sv ====
// nested priority interrupt controller with APB register access
`timescale 1ns/1ps
//
// Overview of operation
// - software clears per-source enable only
// - software sets per-source enable only
// - global gate passes request, enables untouched
// - gate state and previous state readable
// - sleep-after-handler control bit
// - priority readable; invalid number reads -1
// - preempt split readable
// - threshold blocks priority >= threshold; 0 off
// - threshold 4 passes 0-3, holds 4+
// - smaller priority value is more urgent
// - only top three priority bits compared
// - vector base readable, used for fetch
// - enable state readable per source
// - software sets pending bit of any source
// - pended less urgent waits for active handler
// - dispatch only while enabled
// - system exceptions and peripheral lines handled
// - equal priority: lower number first
// - equal preempt level never preempts
// - software clears pending bit
// - groupings three to seven act alike
module npic_ctrl
    import npic_pkg::*;
#(
    parameter int NSRC = npic_pkg::NUM_SRC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // request lines (pins, synchronised inside)
    input  wire logic [NSRC-1:0] src_req,
    // core side
    output logic             core_irq,
    output logic [31:0]      core_vector,
    output logic             sleep_after_handler,
    input  wire logic        core_ack,
    input  wire logic        core_done
);
    import npic_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NSRC-1:0]          sync1;     // first synchroniser stage
        logic [NSRC-1:0]          sync2;     // second stage
        logic [NSRC-1:0]          req_q;     // previous synced level for edge
        logic [NSRC-1:0]          enable;    // per-source enables
        logic [NSRC-1:0]          pending;   // per-source pending
        logic [NSRC-1:0]          active;    // handlers in progress
        logic [NSRC*PRIO_W-1:0]   prio;      // stored 8-bit priorities
        logic                     gate;      // global gate
        logic                     prev_gate; // gate before last control write
        logic                     sleep;     // sleep after handler
        logic [2:0]               group;     // preempt split
        logic [PRIO_W-1:0]        thresh;    // priority threshold
        logic [31:0]              vbase;     // vector base
        logic [SRC_W-1:0]         sel;       // selected source
        logic [SRC_W-1:0]         cur;       // source offered to the core
        logic                     irq;       // request to core
        logic [31:0]              vec;       // vector address offered
        logic [31:0]              rdata;     // read data
    } npic_state_s;

    npic_state_s r;       // registered state
    npic_state_s next_r;  // next state

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // preempt level: top bits kept per grouping, 3..7 all keep three
    function automatic logic [2:0] npic_level(input logic [PRIO_W-1:0] p,
                                              input logic [2:0] grp);
        logic [2:0] top;
        top = p[PRIO_W-1 -: PRIO_BITS];
        case (grp)
            3'h0:    npic_level = 3'h0;
            3'h1:    npic_level = {top[2], 2'b00};
            3'h2:    npic_level = {top[2:1], 1'b0};
            default: npic_level = top;
        endcase
    endfunction

    // full three-bit rank, used to order sources within a level
    function automatic logic [2:0] npic_rank(input logic [PRIO_W-1:0] p);
        npic_rank = p[PRIO_W-1 -: PRIO_BITS];
    endfunction

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic wr_en;        // write takes effect
    logic rd_en;        // read data taken
    logic sel_valid;    // selected number in range
    logic known;        // address mapped
    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = psel & penable & ~pwrite;
    assign sel_valid = 32'(r.sel) < 32'(NSRC);
    assign known     = paddr[1:0] == 2'b00 && paddr <= OFS_ACTIVE;
    // zero-wait slave: reads come straight from state
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~known;

    // ----------------------------------------------------------------
    // arbitration: pick best pending, enabled source
    // ----------------------------------------------------------------
    logic             cand_ok;      // a candidate exists
    logic [SRC_W-1:0] cand;         // its number
    logic [2:0]       cand_rank;    // its rank
    logic             act_ok;       // any handler active
    logic [2:0]       act_level;    // most urgent active preempt level
    logic [SRC_W-1:0] act_src;      // innermost handler, retired first
    always_comb begin
        cand_ok   = 1'b0;
        cand      = '0;
        cand_rank = 3'h7;
        act_ok    = 1'b0;
        act_level = 3'h7;
        act_src   = '0;
        // strict less-than keeps the lowest number on ties
        for (int i = 0; i < NSRC; i++) begin
            if (r.pending[i] && r.enable[i] && !r.active[i] &&
                (!cand_ok || npic_rank(r.prio[i*PRIO_W +: PRIO_W]) < cand_rank)) begin
                cand_ok   = 1'b1;
                cand      = SRC_W'(i);
                cand_rank = npic_rank(r.prio[i*PRIO_W +: PRIO_W]);
            end
            // equal levels never nest, so the most urgent active one is the innermost
            if (r.active[i] && (!act_ok || npic_level(r.prio[i*PRIO_W +: PRIO_W], r.group) < act_level)) begin
                act_ok    = 1'b1;
                act_src   = SRC_W'(i);
                act_level = npic_level(r.prio[i*PRIO_W +: PRIO_W], r.group);
            end
        end
    end

    logic [2:0] cand_level;   // candidate preempt level
    logic       thr_pass;     // threshold allows candidate
    logic       nest_pass;    // candidate may preempt active work
    logic       take;         // candidate offered to core
    assign cand_level = npic_level(r.prio[32'(cand)*PRIO_W +: PRIO_W], r.group);
    // threshold of zero switches masking off
    assign thr_pass   = (npic_rank(r.thresh) == 3'h0) || (cand_rank < npic_rank(r.thresh));
    // equal preempt level chains after, never preempts
    assign nest_pass  = !act_ok || (cand_level < act_level);
    assign take       = cand_ok && thr_pass && nest_pass;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r       = r;
        next_r.sync1 = src_req;
        next_r.sync2 = r.sync1;
        next_r.req_q = r.sync2;
        // core acknowledges: request becomes active, pending drops
        if (r.irq && core_ack) begin
            next_r.active[r.cur]  = 1'b1;
            next_r.pending[r.cur] = 1'b0;
        end
        // handler exit retires the innermost handler; the offered source
        // may already have moved on to a newer candidate, so it cannot
        // be trusted to name the handler that just ended
        if (core_done && act_ok) begin
            next_r.active[act_src] = 1'b0;
        end
        // register writes
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    next_r.prev_gate = r.gate;
                    next_r.gate      = pwdata[CTRL_GATE];
                    next_r.sleep     = pwdata[CTRL_SLEEP];
                end
                OFS_GROUP:  next_r.group  = pwdata[2:0];
                OFS_THRESH: next_r.thresh = pwdata[PRIO_W-1:0];
                OFS_VBASE:  next_r.vbase  = pwdata;
                OFS_SEL:    next_r.sel    = pwdata[SRC_W-1:0];
                OFS_CMD: if (sel_valid) begin
                    if (pwdata[CMD_SET_EN])   next_r.enable[r.sel]  = 1'b1;
                    if (pwdata[CMD_CLR_EN])   next_r.enable[r.sel]  = 1'b0;
                    if (pwdata[CMD_CLR_PEND]) next_r.pending[r.sel] = 1'b0;
                    if (pwdata[CMD_SET_PEND]) next_r.pending[r.sel] = 1'b1;
                end
                OFS_PRIO: if (sel_valid) begin
                    next_r.prio[32'(r.sel)*PRIO_W +: PRIO_W] = pwdata[PRIO_W-1:0];
                end
                default: ;
            endcase
        end
        // rising request edges set pending; set wins over any clear
        next_r.pending = next_r.pending | (r.sync2 & ~r.req_q);
        // offer to core
        next_r.irq = take && r.gate;
        if (take) begin
            next_r.cur = cand;
            next_r.vec = r.vbase + {24'h0, cand, 2'b00};
        end
        // read data
        next_r.rdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CTRL:   next_r.rdata = {29'h0, r.prev_gate, r.sleep, r.gate};
                OFS_GROUP:  next_r.rdata = {29'h0, r.group};
                OFS_THRESH: next_r.rdata = {24'h0, r.thresh};
                OFS_VBASE:  next_r.rdata = r.vbase;
                OFS_SEL:    next_r.rdata = {26'h0, r.sel};
                OFS_PRIO:   next_r.rdata = sel_valid ?
                                {24'h0, r.prio[32'(r.sel)*PRIO_W +: PRIO_W]} : BAD_PRIO;
                OFS_STAT:   next_r.rdata = sel_valid ?
                                {29'h0, r.active[r.sel], r.pending[r.sel], r.enable[r.sel]} : 32'h0;
                OFS_ACTIVE: next_r.rdata = {25'h0, r.irq, r.cur} ;
                default:    next_r.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.vbase <= RST_VBASE;
            r.group <= RST_GROUP;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign prdata              = r.rdata;
    assign core_irq            = r.irq;
    assign core_vector         = r.vec;
    assign sleep_after_handler = r.sleep;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // all checks run on pclk and sleep while reset is low
    // a closed gate keeps the core request low
    AST_GATE_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
        !r.gate |=> !core_irq)
        else $error("request passed closed gate");
    // toggling the gate leaves every per-source enable alone
    AST_ENABLE_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CTRL) |=> r.enable == $past(r.enable))
        else $error("gate write touched enables");
    // only pending, enabled sources are offered
    AST_DISPATCH_ENABLED: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> r.enable[cand] && r.pending[cand])
        else $error("dispatch of disabled source");
    // a threshold of non-zero rank holds off its own rank and every less urgent one
    AST_THRESH: assert property (@(posedge pclk) disable iff (!presetn)
        (take && npic_rank(r.thresh) != 3'h0) |-> cand_rank < npic_rank(r.thresh))
        else $error("threshold not honoured");
    // an offer during a handler must come from a more urgent level
    AST_NEST: assert property (@(posedge pclk) disable iff (!presetn)
        (take && act_ok) |-> cand_level < act_level)
        else $error("equal level preempted");
    // software pend lands on the selected source
    AST_PEND_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CMD && pwdata[CMD_SET_PEND] && sel_valid) |=> r.pending[$past(r.sel)])
        else $error("pending not set");
    // software unpend drops the request unless a line edge sets it again
    AST_PEND_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CMD && sel_valid && pwdata[CMD_CLR_PEND] && !pwdata[CMD_SET_PEND] &&
         !r.sync2[r.sel]) |=> !r.pending[$past(r.sel)])
        else $error("pending not cleared");
    // set-enable command lands on the selected source
    AST_ENABLE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CMD && sel_valid && pwdata[CMD_SET_EN] && !pwdata[CMD_CLR_EN]) |=>
        r.enable[$past(r.sel)])
        else $error("enable not set");
    // clear-enable command lands on the selected source
    AST_ENABLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CMD && sel_valid && pwdata[CMD_CLR_EN]) |=> !r.enable[$past(r.sel)])
        else $error("enable not cleared");
    // an out-of-range number reads back as all ones
    AST_BAD_PRIO: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_PRIO && !sel_valid) |=> prdata == BAD_PRIO)
        else $error("invalid priority read not -1");
    // a control write remembers the gate as it was
    AST_PREV_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CTRL) |=> r.prev_gate == $past(r.gate))
        else $error("previous gate lost");
    // the sleep control pin follows the written bit
    AST_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_CTRL) |=> sleep_after_handler == $past(pwdata[CTRL_SLEEP]))
        else $error("sleep control not taken");
    // handler exit leaves the innermost handler inactive
    AST_DONE_RETIRES: assert property (@(posedge pclk) disable iff (!presetn)
        (core_done && act_ok) |=> !r.active[$past(act_src)])
        else $error("ended handler still active");
endmodule

// ==== rtl/npic_pkg.sv ====
// package of constants for the nested priority interrupt controller
package npic_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC      = 64;       // sources: 16 system slots + 48 peripheral lines
    localparam int NUM_SYS      = 16;       // first peripheral line sits at this number
    localparam int SRC_W        = 6;        // width of a source number
    localparam int PRIO_W       = 8;        // stored priority width
    localparam int PRIO_BITS    = 3;        // implemented upper priority bits
    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL     = 12'h000; // gate, sleep-after-handler
    localparam logic [11:0] OFS_GROUP    = 12'h004; // preempt split
    localparam logic [11:0] OFS_THRESH   = 12'h008; // priority threshold
    localparam logic [11:0] OFS_VBASE    = 12'h00c; // vector base
    localparam logic [11:0] OFS_SEL      = 12'h010; // selected source number
    localparam logic [11:0] OFS_CMD      = 12'h014; // commands on selected source
    localparam logic [11:0] OFS_PRIO     = 12'h018; // priority of selected source
    localparam logic [11:0] OFS_STAT     = 12'h01c; // enable/pending/active of selected
    localparam logic [11:0] OFS_ACTIVE   = 12'h020; // request flag, offered source number
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_GATE    = 0;        // global gate open
    localparam int CTRL_SLEEP   = 1;        // sleep after handler
    localparam int CTRL_PREV    = 2;        // gate state before last control write (read)
    localparam int CMD_SET_EN   = 0;        // set_source_enable
    localparam int CMD_CLR_EN   = 1;        // clear_source_enable
    localparam int CMD_SET_PEND = 2;        // set_source_pending
    localparam int CMD_CLR_PEND = 3;        // clear_source_pending
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_VBASE   = 32'h0000_0000;
    localparam logic [2:0]  RST_GROUP   = 3'h0;
    localparam logic [31:0] BAD_PRIO    = 32'hffff_ffff; // -1 for invalid number
endpackage

// ==== bench/npic_core_model.sv ====
// behavioural processor core that takes offered interrupts
`timescale 1ns/1ps
module npic_core_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // controller side
    input  wire logic       core_irq,
    output logic            core_ack,
    output logic            core_done,
    // bench control: stall and handler length
    input  wire logic       accept,
    input  wire logic [7:0] hold_cycles
);
    // ----------------------------------------------------------------
    // state: one handler at a time, nesting is left to the controller
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       ack;    // take pulse
        logic       done;   // handler end pulse
        logic       busy;   // inside a handler
        logic [7:0] cnt;    // cycles left in the handler
    } npic_core_s;
    npic_core_s st;
    npic_core_s next_st;
    // a stalled core ignores the request, so pending work piles up
    always_comb begin
        next_st      = st;
        next_st.ack  = 1'b0;
        next_st.done = 1'b0;
        if (!st.busy) begin
            if (core_irq && accept) begin
                next_st.ack  = 1'b1;
                next_st.busy = 1'b1;
                next_st.cnt  = hold_cycles;
            end
        end else if (st.cnt != 8'h00) begin
            next_st.cnt = st.cnt - 8'h01;
        end else begin
            next_st.done = 1'b1;
            next_st.busy = 1'b0;
        end
    end
    // register the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign core_ack  = st.ack;
    assign core_done = st.done;
endmodule

// ==== bench/testbench.sv ====
// self-checking testbench for the nested priority interrupt controller
`timescale 1ns/1ps
module testbench;
    import npic_pkg::*;
    localparam int          NS = 48;                // numbers 48..63 are invalid here
    localparam logic [31:0] VB = 32'h2000_0400;     // vector base used throughout
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } npic_row_s;                                   // write d to a, read back e
    npic_row_s     rows [7] = '{'{OFS_THRESH, 32'ha5, 32'ha5}, '{OFS_VBASE, VB, VB}, '{OFS_GROUP, 32'h5, 32'h5},
                                '{OFS_CTRL, 32'h3, 32'h3}, '{OFS_CTRL, 32'h0, 32'h4}, '{OFS_SEL, 32'h2a, 32'h2a},
                                '{OFS_THRESH, 32'h0, 32'h0}};
    logic [8:0]    thr_tab [5] = '{9'h080, 9'h1a0, 9'h09f, 9'h100, 9'h020};  // {irq expected, threshold}
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, accept = 1'b0;
    logic          pready, pslverr, core_irq, core_ack, core_done, sleep_after_handler, err;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0, prdata, core_vector, rv;
    logic [NS-1:0] src_req = '0;
    logic [7:0]    hold_cycles = 8'h28;             // long handler so work can pile up behind it
    int            n_mismatch = 0, total_checks = 0;
    always #50 pclk = ~pclk;
    npic_ctrl #(.NSRC(NS)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .core_irq(core_irq), .core_vector(core_vector), .sleep_after_handler(sleep_after_handler),
        .core_ack(core_ack), .core_done(core_done));
    npic_core_model core (.pclk(pclk), .presetn(presetn), .core_irq(core_irq), .core_ack(core_ack),
        .core_done(core_done), .accept(accept), .hold_cycles(hold_cycles));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // let the registered outputs follow the last write
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask
    // select a source, give it a priority and issue commands
    task automatic src(input logic [5:0] n, input logic [7:0] p, input logic [3:0] c);
        apb(1'b1, OFS_SEL, {26'h0, n});
        apb(1'b1, OFS_PRIO, {24'h0, p});
        apb(1'b1, OFS_CMD, {28'h0, c});
        settle;
    endtask
    // wait for a core pulse (0 take, 1 handler end), bounded
    task automatic wait_pulse(input logic which);
        int k;
        k = 0;
        while ((which ? core_done : core_ack) !== 1'b1 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        chk({31'h0, k < 300}, 32'h1);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_of_test;
    end
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk({29'h0, pready, core_irq, sleep_after_handler}, 32'h4);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rv, rows[i].e);
        end
        apb(1'b1, OFS_CTRL, 32'h2);
        settle;
        chk({31'h0, sleep_after_handler}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        settle;
        chk({31'h0, sleep_after_handler}, 32'h0);
        src(6'd20, 8'h40, 4'h4);                                    // pend while the gate is closed
        chk({31'h0, core_irq}, 32'h0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h2);
        apb(1'b0, OFS_PRIO, 32'h0);
        chk(rv, 32'h40);
        apb(1'b1, OFS_CTRL, 32'h1);
        src(6'd20, 8'h80, 4'h1);                                    // enable only now
        chk({31'h0, core_irq}, 32'h1);
        chk(core_vector, VB + 32'd80);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h0);
        settle;
        chk({31'h0, core_irq}, 32'h0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h3);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h4);
        apb(1'b1, OFS_CTRL, 32'h1);
        foreach (thr_tab[i]) begin
            apb(1'b1, OFS_THRESH, {24'h0, thr_tab[i][7:0]});
            settle;
            chk({31'h0, core_irq}, {31'h0, thr_tab[i][8]});
        end
        apb(1'b1, OFS_THRESH, 32'h0);
        src(6'd22, 8'h80, 4'h5);                                    // same level as source 20
        chk(core_vector, VB + 32'd80);
        src(6'd25, 8'h20, 4'h5);
        chk(core_vector, VB + 32'd100);
        src(6'd25, 8'h20, 4'h8);
        chk(core_vector, VB + 32'd80);
        src(6'd20, 8'h80, 4'h2);
        chk(core_vector, VB + 32'd88);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h2);
        accept <= 1'b1;
        wait_pulse(1'b0);
        accept <= 1'b0;
        src(6'd26, 8'ha0, 4'h5);                                    // less urgent than the active one
        chk({31'h0, core_irq}, 32'h0);
        wait_pulse(1'b1);
        settle;
        chk({31'h0, core_irq}, 32'h1);
        chk(core_vector, VB + 32'd104);
        accept <= 1'b1;
        wait_pulse(1'b0);
        wait_pulse(1'b1);
        accept <= 1'b0;
        settle;
        chk({31'h0, core_irq}, 32'h0);
        apb(1'b1, OFS_GROUP, 32'h1);                                // one preempt bit only
        src(6'd27, 8'he0, 4'h5);
        chk(core_vector, VB + 32'd108);
        accept <= 1'b1;
        wait_pulse(1'b0);
        accept <= 1'b0;
        src(6'd28, 8'h80, 4'h5);                                    // same preempt level as 27
        chk({31'h0, core_irq}, 32'h0);
        apb(1'b1, OFS_GROUP, 32'h3);                                // full split: 28 outranks 27
        settle;
        chk({31'h0, core_irq}, 32'h1);
        chk(core_vector, VB + 32'd112);
        wait_pulse(1'b1);
        apb(1'b1, OFS_SEL, 32'd27);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h1);
        apb(1'b1, OFS_SEL, 32'h32);
        apb(1'b0, OFS_PRIO, 32'h0);
        chk(rv, BAD_PRIO);
        src_req[30] <= 1'b1;
        src(6'd30, 8'h60, 4'h0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h2);
        apb(1'b0, 12'h024, 32'h0);
        chk({31'h0, err}, 32'h1);
        presetn <= 1'b0;
        settle;
        presetn <= 1'b1;
        apb(1'b1, OFS_SEL, 32'd20);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, OFS_PRIO, 32'h0);
        chk(rv, 32'h0);
        end_of_test;
    end
endmodule
